// ### rtl/gfcs_clock_switch.sv
// glitch-free two-input clock switch with staged handover and fail-safe hold
//
// Functional notes
// - with staged handover on, a source change ends within 17 input clock cycles.
// - with staged handover on, no shortened high or low pulse appears on the output clock during a handover.
// - both inputs use identical sequencing, so either may be primary.
// - with staged handover off, a select change switches the output at once.
// - startup delay pin tied high statically disables staged handover, plain mux.
// - selected input losing amplitude holds the output at its last level.
// - select change while both run starts a three-stage handover.
// - stage one keeps passing the old clock for a bounded number of pulses.
// - stage two drives the output low for bounded alternate clock pulses.
// - stage three passes the alternate clock continuously.
// - stage pulse counts may vary within bounds due to asynchronous inputs.
// - old clock stuck high holds output high, then low, then follows alternate.
// - old clock stuck low keeps output low, then follows the alternate clock.
// - a stretched cycle has high and low parts above half the alternate period.
// - reset puts the sequencing into a known state before use.
`timescale 1ns/1ps
`default_nettype none

module gfcs_clock_switch
  import gfcs_pkg::*;
(
  // system
  input wire logic clk_sys,
  input wire logic sys_rst,
  // clock inputs with amplitude flags
  input wire logic clock_input_a,
  input wire logic clock_input_a_ok,
  input wire logic clock_input_b,
  input wire logic clock_input_b_ok,
  // source select and startup strap
  input wire logic select_b,
  input wire logic startup_delay_pin,
  // output clock and status
  output logic clk_out_q,
  output logic active_b_q,
  output logic switching_q,
  output logic runt_pulse_eliminator_q
);

  // ---------------------------------------------------------------
  // input sampling, one identical channel per input
  // ---------------------------------------------------------------
  logic a_lvl, a_rise, a_fall, a_ok;
  logic b_lvl, b_rise, b_fall, b_ok;

  gfcs_edge_det u_chan_a (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_in(clock_input_a),
    .ok_in(clock_input_a_ok),
    .level(a_lvl),
    .rise(a_rise),
    .fall(a_fall),
    .ok(a_ok)
  );

  gfcs_edge_det u_chan_b (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_in(clock_input_b),
    .ok_in(clock_input_b_ok),
    .level(b_lvl),
    .rise(b_rise),
    .fall(b_fall),
    .ok(b_ok)
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  gfcs_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] stuck_q, stuck_d;
  logic sel_s1_q, sel_s2_q;
  logic active_q, active_d;
  logic rpe_q, rpe_d;
  logic out_d;
  logic switching_d;

  // old is the running source, new the requested one
  logic old_lvl, old_rise, old_fall, old_ok;
  logic new_lvl, new_rise, new_fall;
  logic sel_lvl, sel_ok;

  // source routing, symmetric for both inputs
  always_comb
  begin
    old_lvl = active_q ? b_lvl : a_lvl;
    old_rise = active_q ? b_rise : a_rise;
    old_fall = active_q ? b_fall : a_fall;
    old_ok = active_q ? b_ok : a_ok;
    new_lvl = active_q ? a_lvl : b_lvl;
    new_rise = active_q ? a_rise : b_rise;
    new_fall = active_q ? a_fall : b_fall;
    sel_lvl = sel_s2_q ? b_lvl : a_lvl;
    sel_ok = sel_s2_q ? b_ok : a_ok;
  end

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  // leaving stage one on the fall count only while the old clock is low means no high runt
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    stuck_d = stuck_q;
    active_d = active_q;
    rpe_d = rpe_q;
    out_d = clk_out_q;
    case (state_q)
      st_init:
      begin
        // strap read once; later changes of the pin are ignored
        if (cnt_q == INIT_LAST)
        begin
          state_d = st_follow;
          active_d = sel_s2_q;
          rpe_d = ~startup_delay_pin;
          cnt_d = CNT_ZERO;
        end
        else
        begin
          cnt_d = cnt_q + CNT_ONE;
        end
      end
      st_follow:
      begin
        if (!rpe_q)
        begin
          active_d = sel_s2_q;
          out_d = sel_ok ? sel_lvl : clk_out_q;
        end
        else
        begin
          if (sel_s2_q != active_q)
          begin
            state_d = st_old;
            cnt_d = CNT_ZERO;
            stuck_d = CNT_ZERO;
          end
          out_d = old_ok ? old_lvl : clk_out_q;
        end
      end
      st_old:
      begin
        if (old_fall && cnt_q != OLD_FALLS)
          cnt_d = cnt_q + CNT_ONE;
        if (old_rise || old_fall)
          stuck_d = CNT_ZERO;
        else if (new_rise && stuck_q != STUCK_RISES)
          stuck_d = stuck_q + CNT_ONE;
        if ((cnt_q == OLD_FALLS && !old_lvl) || stuck_q == STUCK_RISES)
        begin
          state_d = st_low;
          cnt_d = CNT_ZERO;
          out_d = 1'b0;
        end
        else
        begin
          out_d = old_ok ? old_lvl : clk_out_q;
        end
      end
      st_low:
      begin
        out_d = 1'b0;
        if (new_fall && cnt_q != LOW_FALLS)
          cnt_d = cnt_q + CNT_ONE;
        // hand over only while the new clock is low: no low runt either
        if (cnt_q == LOW_FALLS && !new_lvl)
        begin
          state_d = st_follow;
          active_d = ~active_q;
          cnt_d = CNT_ZERO;
        end
      end
      default:
      begin
        state_d = st_init;
      end
    endcase
    switching_d = (state_d == st_old) || (state_d == st_low);
  end

  // select crosses in through two flops; only the second is read
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sel_s1_q <= 1'b0;
      sel_s2_q <= 1'b0;
    end
    else
    begin
      sel_s1_q <= select_b;
      sel_s2_q <= sel_s1_q;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= st_init;
      cnt_q <= CNT_ZERO;
      stuck_q <= CNT_ZERO;
      active_q <= 1'b0;
      rpe_q <= 1'b1;
      clk_out_q <= 1'b0;
      switching_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      stuck_q <= stuck_d;
      active_q <= active_d;
      rpe_q <= rpe_d;
      clk_out_q <= out_d;
      switching_q <= switching_d;
    end
  end

  assign active_b_q = active_q;
  assign runt_pulse_eliminator_q = rpe_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // alternate rising edges seen during one handover
  logic [SW_W-1:0] sw_edges_q, sw_edges_d;

  always_comb
  begin
    sw_edges_d = sw_edges_q;
    if (state_q == st_follow || state_q == st_init)
      sw_edges_d = SW_ZERO;
    else if (new_rise && sw_edges_q != SW_SAT)
      sw_edges_d = sw_edges_q + SW_ONE;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      sw_edges_q <= SW_ZERO;
    else
      sw_edges_q <= sw_edges_d;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  chk_switch_bound: assert property (sw_edges_q <= SW_LIMIT)
    else $error("handover took too many alternate cycles");
  chk_low_stage: assert property (state_q == st_low |=> !clk_out_q)
    else $error("output not low in stage two");
  chk_handover_low: assert property
    (state_q == st_follow && $past(state_q) == st_low |-> !clk_out_q && !$past(clk_out_q))
    else $error("handover did not start from low");
  chk_follow_sel: assert property
    (state_q == st_follow && rpe_q && old_ok |=> clk_out_q == $past(old_lvl))
    else $error("output does not follow active clock");
  chk_plain_mux: assert property
    (state_q == st_follow && !rpe_q && sel_ok |=> clk_out_q == $past(sel_lvl) && active_q == $past(sel_s2_q))
    else $error("plain mux did not switch at once");
  chk_failsafe_hold: assert property
    (state_q == st_follow && ((rpe_q && !old_ok) || (!rpe_q && !sel_ok)) |=> $stable(clk_out_q))
    else $error("output moved while input lost");
  chk_start_stage: assert property
    (state_q == st_follow && rpe_q && sel_s2_q != active_q |=> state_q == st_old && switching_q)
    else $error("select change did not start handover");
  chk_por_direct: assert property
    (state_q == st_follow && $past(state_q) == st_init |-> active_q == $past(sel_s2_q))
    else $error("startup source differs from select");
  chk_stage_order: assert property
    (state_q == st_old |=> state_q == st_old || state_q == st_low)
    else $error("stage one left to wrong state");
  chk_strap_static: assert property
    (state_q != st_init |=> $stable(rpe_q))
    else $error("strap setting changed after startup");

  cov_staged_switch: cover property (state_q == st_low ##1 state_q == st_follow);
  cov_stuck_timeout: cover property (state_q == st_old && stuck_q == STUCK_RISES);
  cov_failsafe: cover property (state_q == st_follow && rpe_q && !old_ok);
  cov_plain_switch: cover property (!rpe_q && state_q == st_follow && $changed(active_q));

endmodule // gfcs_clock_switch

`default_nettype wire

// ### rtl/gfcs_pkg.sv
// package: constants and types for the glitch-free clock switch
package gfcs_pkg;

  // ---------------------------------------------------------------
  // sequencing states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {st_init, st_follow, st_old, st_low} gfcs_state_t;

  // ---------------------------------------------------------------
  // counts, in edges of the input clocks except the startup count
  // ---------------------------------------------------------------
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
  // falling edges of the old clock still passed in stage one
  localparam logic [CNT_W-1:0] OLD_FALLS = 3'h2;
  // alternate rising edges without an old edge that mark the old clock as stuck
  localparam logic [CNT_W-1:0] STUCK_RISES = 3'h3;
  // alternate falling edges with the output held low in stage two
  localparam logic [CNT_W-1:0] LOW_FALLS = 3'h2;
  // system cycles spent in startup before the strap and select are trusted
  localparam logic [CNT_W-1:0] INIT_LAST = 3'h2;

  // longest handover, in alternate clock cycles
  localparam int SWITCH_MAX_EDGES = 17;
  localparam int SW_W = 5;
  localparam logic [SW_W-1:0] SW_ZERO = 5'h00;
  localparam logic [SW_W-1:0] SW_ONE = 5'h01;
  localparam logic [SW_W-1:0] SW_SAT = 5'h1f;
  localparam logic [SW_W-1:0] SW_LIMIT = 5'h11;

endpackage : gfcs_pkg

// ### rtl/gfcs_edge_det.sv
// one sampled clock input: level, edges and amplitude flag
`timescale 1ns/1ps
`default_nettype none

module gfcs_edge_det
  import gfcs_pkg::*;
(
  // system
  input wire logic clk_sys,
  input wire logic sys_rst,
  // sampled clock input and its amplitude flag
  input wire logic clk_in,
  input wire logic ok_in,
  // results
  output logic level,
  output logic rise,
  output logic fall,
  output logic ok
);

  logic lvl_q, lvl_d;
  logic prev_q, prev_d;
  logic ok_q, ok_d;

  // ---------------------------------------------------------------
  // sample and edge detection
  // ---------------------------------------------------------------
  // a lost input keeps its last level, so no edge is ever made up
  always_comb
  begin
    ok_d = ok_in;
    lvl_d = ok_in ? clk_in : lvl_q;
    prev_d = lvl_q;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lvl_q <= 1'b0;
      prev_q <= 1'b0;
      ok_q <= 1'b0;
    end
    else
    begin
      lvl_q <= lvl_d;
      prev_q <= prev_d;
      ok_q <= ok_d;
    end
  end

  assign level = lvl_q;
  assign rise = lvl_q & ~prev_q;
  assign fall = ~lvl_q & prev_q;
  assign ok = ok_q;

endmodule // gfcs_edge_det

`default_nettype wire

// ### tb/gfcs_src_model.sv
// far-side model: two clock sources with amplitude-loss control
`timescale 1ns/1ps
`default_nettype none

module gfcs_src_model (
  // system
  input wire logic clk_sys,
  // source control
  input wire logic [2:0] half_a,
  input wire logic [2:0] half_b,
  input wire logic run_a,
  input wire logic run_b,
  input wire logic ok_a,
  input wire logic ok_b,
  // clock pins
  output logic clock_input_a = 1'b0,
  output logic clock_input_b = 1'b0
);
  int ca = 0;
  int cb = 0;
  logic la = 1'b0;
  logic lb = 1'b0;

  // sources step off the sampling edge; a halted source freezes its level
  always @(negedge clk_sys)
  begin
    ca = run_a ? ca + 1 : 0;
    cb = run_b ? cb + 1 : 0;
    if (ca >= int'(half_a))
    begin
      ca = 0;
      la = ~la;
    end
    if (cb >= int'(half_b))
    begin
      cb = 0;
      lb = ~lb;
    end
    // lost amplitude: pin churns, never shows a clean level
    clock_input_a <= ok_a ? la : ~clock_input_a;
    clock_input_b <= ok_b ? lb : ~clock_input_b;
  end
endmodule // gfcs_src_model

`default_nettype wire

// ### tb/glitch_free_clock_switch_mux_tb.sv
// testbench: clock switch against a delayed-copy model
`timescale 1ns/1ps
`default_nettype none

module glitch_free_clock_switch_mux_tb;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic select_b = 1'b0;
  logic strap = 1'b0;
  logic run_a = 1'b1;
  logic run_b = 1'b1;
  logic ok_a = 1'b1;
  logic ok_b = 1'b1;
  logic [2:0] half_a = 3'h4;
  logic [2:0] half_b = 3'h4;
  logic in_a, in_b, clk_out_q, active_b_q, switching_q, rpe_q;
  logic pa = 1'b0;
  logic pb = 1'b0;
  logic lastq = 1'b0;
  logic last_act = 1'b0;
  bit rpe_on = 1'b1;
  int mismatches = 0;
  int n_compared = 0;
  int seed = 90;
  int quiet = 0;
  int run = 0;
  int trans = 0;

  always #20 clk_sys = ~clk_sys;

  gfcs_src_model src (.clk_sys(clk_sys), .half_a(half_a), .half_b(half_b), .run_a(run_a),
    .run_b(run_b), .ok_a(ok_a), .ok_b(ok_b), .clock_input_a(in_a), .clock_input_b(in_b));

  gfcs_clock_switch dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clock_input_a(in_a),
    .clock_input_a_ok(ok_a), .clock_input_b(in_b), .clock_input_b_ok(ok_b),
    .select_b(select_b), .startup_delay_pin(strap), .clk_out_q(clk_out_q),
    .active_b_q(active_b_q), .switching_q(switching_q), .runt_pulse_eliminator_q(rpe_q));

  task automatic fail(input string msg);
    mismatches++;
    $display("[ERR] %0t %s", $time, msg);
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic got, input logic exp, input string msg);
    n_compared++;
    if (got !== exp)
      fail(msg);
  endtask

  // model: in steady follow the output is the chosen pin two cycles late
  always @(negedge clk_sys)
  begin
    if (sys_rst)
    begin
      quiet = 0;
      trans = 0;
    end
    else
    begin
      if (quiet >= 5)
      begin
        n_compared++;
        if (clk_out_q !== (active_b_q ? pb : pa)) fail("output differs from model");
      end
      if (switching_q !== 1'b0 || !(active_b_q ? ok_b : ok_a) || active_b_q !== last_act)
        quiet = 0;
      else
        quiet++;
      // recovery from a lost input may cut a pulse; that is no handover runt
      if (!(active_b_q ? ok_b : ok_a))
        trans = 0;
      // every source half period is at least 4 cycles, so shorter is a runt
      if (clk_out_q !== lastq)
      begin
        if (rpe_on && trans >= 2 && run < 4) fail("short output pulse");
        trans++;
        run = 0;
      end
      run++;
    end
    lastq = clk_out_q;
    last_act = active_b_q;
    pa = in_a;
    pb = in_b;
  end

  task automatic do_reset(input logic s);
    strap = s;
    sys_rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (6) @(negedge clk_sys);
    rpe_on = !s;
    check(rpe_q, !s, "strap not honoured");
    check(active_b_q, select_b, "wrong source after reset");
  endtask

  // stuck < 0: both run; else old source frozen at that level first
  task automatic do_switch(input logic tgt, input int stuck);
    int i;
    int edges;
    bit seen;
    logic pn;
    edges = 0;
    seen = 0;
    if (stuck >= 0)
    begin
      for (i = 0; i < 40 && (tgt ? in_a : in_b) !== stuck[0]; i++) @(negedge clk_sys);
      if (i >= 40) wrap_up_hang();
      if (tgt) run_a = 1'b0;
      else run_b = 1'b0;
      repeat (12) @(negedge clk_sys);
    end
    select_b = tgt;
    pn = tgt ? in_b : in_a;
    for (i = 0; i < 400 && active_b_q !== tgt; i++)
    begin
      @(negedge clk_sys);
      if (switching_q === 1'b1) seen = 1;
      if (!pn && (tgt ? in_b : in_a)) edges++;
      pn = tgt ? in_b : in_a;
    end
    if (i >= 400) wrap_up_hang();
    n_compared++;
    if (rpe_on && (edges > 17 || !seen)) fail("handover too long or not staged");
    if (!rpe_on && (i > 4 || seen)) fail("plain switch not immediate");
    run_a = 1'b1;
    run_b = 1'b1;
  endtask

  task automatic wrap_up_hang;
    fail("wait for handover timed out");
    wrap_up();
  endtask

  task automatic do_failsafe;
    logic lvl;
    if (active_b_q) ok_b = 1'b0;
    else ok_a = 1'b0;
    repeat (3) @(negedge clk_sys);
    lvl = clk_out_q;
    repeat (20)
    begin
      @(negedge clk_sys);
      check(clk_out_q, lvl, "output not held on lost input");
    end
    ok_a = 1'b1;
    ok_b = 1'b1;
    // let the restored input run before anything else is asked
    repeat (8) @(negedge clk_sys);
  endtask

  initial
  begin
    do_reset(1'b0);
    // ratio stays within 1.5 to 1: 4..5 against 4..6
    repeat (6)
    begin
      half_a = 3'h4 + 3'($unsigned($random(seed)) % 2);
      half_b = 3'h4 + 3'($unsigned($random(seed)) % 3);
      repeat (20 + $unsigned($random(seed)) % 30) @(negedge clk_sys);
      do_switch(!active_b_q, -1);
    end
    for (int k = 0; k < 4; k++) do_switch(!active_b_q, k / 2);
    repeat (30) @(negedge clk_sys);
    do_failsafe();
    repeat (2)
    begin
      do_switch(!active_b_q, -1);
      do_failsafe();
    end
    do_reset(1'b1);
    repeat (3) do_switch(!active_b_q, -1);
    do_reset(1'b0);
    repeat (40) @(negedge clk_sys);
    wrap_up();
  end
endmodule // glitch_free_clock_switch_mux_tb

`default_nettype wire
